// File: src/ctp_defines.svh
// Constants for the capture trigger position controller.
// Assumes inclusion by bare name from every design file that needs them.
//
// Overview of operation
// - Early ratio keeps 12% before, 88% after
// - Centred ratio keeps half before, half after
// - Late ratio keeps 88% before, 12% after
// - Ratios apply alike to buffer and segments
// - Separate position settings for run-time and power-up
// - Post-fill count captures exactly that many samples
// - Trigger index equals depth minus post-fill
// - Segment without post-fill uses fixed ratio
// - Power-up set armed at configuration, no start; here it arms once the enable bit is set, if no run has started since reset
// - Two independent trigger condition sets kept
// - Trigger input must hold before other conditions
// - Trigger input match pattern per condition set
// - Power-up shares trigger input and output
// - Trigger output driven active on trigger
// - Trigger output level configurable per set
// - Trigger action ends run after post-fill
// - Segment close advances, oldest overwritten when full
`ifndef CTP_DEFINES_SVH
`define CTP_DEFINES_SVH

// Register offsets, word addresses on the plain port
`define CTP_ADDR_CTRL 4'h0
`define CTP_ADDR_RT_CFG 4'h1
`define CTP_ADDR_PU_CFG 4'h2
`define CTP_ADDR_STATUS 4'h3
`define CTP_ADDR_IRQ_STAT 4'h4
`define CTP_ADDR_IRQ_MASK 4'h5
`define CTP_ADDR_TRIG_IDX 4'h6
`define CTP_ADDR_SEG_SEL 4'h7

// Control register bits
`define CTP_CTRL_START 0
`define CTP_CTRL_STOP 1
`define CTP_CTRL_PU_EN 2
`define CTP_CTRL_SEGMENTED 3

// Set configuration fields
`define CTP_CFG_RATIO_LSB 0
`define CTP_CFG_RATIO_MSB 1
`define CTP_CFG_TIN_EN 2
`define CTP_CFG_TIN_PAT_LSB 3
`define CTP_CFG_TIN_PAT_MSB 4
`define CTP_CFG_TOUT_HIGH 5

// Interrupt bits
`define CTP_IRQ_TRIG 0
`define CTP_IRQ_SEG 1
`define CTP_IRQ_DONE 2
`define CTP_IRQ_W 3

// Ratio percentages
`define CTP_PCT_EARLY 12
`define CTP_PCT_HALF 50
`define CTP_PCT_LATE 88
`define CTP_PCT_FULL 100

// Reset values
`define CTP_CFG_RESET 6'h01
`define CTP_CTRL_RESET 4'h0

`endif

// File: src/ctp_pkg.sv
// Types shared by the position controller and its counting leaf.
// Assumes ctp_defines.svh is on the include path.
package ctp_pkg;
    // Fixed pre/post ratio selection
    typedef enum logic [1:0] {CTP_RATIO_EARLY, CTP_RATIO_HALF, CTP_RATIO_LATE, CTP_RATIO_SPARE} ctp_ratio_e;
    // Trigger input match pattern
    typedef enum logic [1:0] {CTP_PAT_LOW, CTP_PAT_HIGH, CTP_PAT_RISE, CTP_PAT_FALL} ctp_pat_e;
endpackage : ctp_pkg

// File: src/ctp_fill_if.sv
// Interface between controller and post-fill counter.
// Assumes one clock domain shared by both ends.
`timescale 1ns/1ps
`default_nettype none
interface ctp_fill_if #(parameter int CW = 10);
    logic load;            // Load a new post-fill amount
    logic [CW-1:0] amount; // Samples still to take
    logic step;            // One sample stored
    logic done;            // Count reached zero while running
    logic busy;            // Counting in progress
    modport ctl (output load, output amount, output step, input done, input busy);
    modport cnt (input load, input amount, input step, output done, output busy);
endinterface : ctp_fill_if
`default_nettype wire

// File: src/ctp_fill_counter.sv
// Post-fill down counter: counts stored samples after a trigger.
// Assumes samples are marked by a one-cycle step from the controller.
`timescale 1ns/1ps
`default_nettype none
module ctp_fill_counter #(parameter int CW = 10) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    ctp_fill_if.cnt fill
);
    import ctp_pkg::*;
    logic [CW-1:0] left;       // Samples still owed
    logic running;             // Counting active
    logic [CW-1:0] next_left;
    logic next_running;

    ////////////////////////////////////////////////////////////////
    // Next value: load wins, then count down on each step
    always_comb
    begin
        next_left = left;
        next_running = running;
        if (fill.load)
        begin
            next_left = fill.amount;
            next_running = 1'b1;
        end
        else if (running && fill.step && left != '0)
        begin
            next_left = left - 1'b1;
        end
        else if (running && left == '0)
        begin
            next_running = 1'b0;
        end
    end

    // Registers, frozen while the enable is low
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            left <= '0;
            running <= 1'b0;
        end
        else if (ce)
        begin
            left <= next_left;
            running <= next_running;
        end
    end

    // Done once the owed count is used up
    assign fill.done = running && (left == '0) && !fill.load;
    assign fill.busy = running;
endmodule : ctp_fill_counter
`default_nettype wire

// File: src/ctp_capture_ctrl.sv
// Trigger position and external trigger controller for the analyzer.
// Assumes write and read strobes are one cycle, synchronous to clk;
// condition match and action inputs come from the trigger flow logic.
//
// Decided for this implementation: the register addresses and the address-and-strobe port.
`include "ctp_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module ctp_capture_ctrl #(
    parameter int DEPTH = 512,   // Samples per segment or buffer
    parameter int SEGS = 4,      // Number of segments
    parameter int CW = 10        // Counter width
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic [3:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic sample_valid,
    input wire logic trig_in,
    input wire logic cond_rt,
    input wire logic cond_pu,
    input wire logic seg_close,
    input wire logic fill_valid,
    input wire logic [CW-1:0] fill_count,
    output logic store_en,
    output logic [CW-1:0] wr_ptr,
    output logic [$clog2(SEGS)-1:0] seg_idx,
    output logic trig_out,
    output logic irq
);
    import ctp_pkg::*;

    // Elaboration check: depth must fit the counters, at least one segment
    if (DEPTH < 2 || DEPTH > (1 << CW) - 1 || SEGS < 1)
    begin : g_bad_param
        $error("ctp_capture_ctrl: unsupported DEPTH, SEGS or CW");
    end

    localparam int SW = (SEGS > 1) ? $clog2(SEGS) : 1;
    localparam logic [CW-1:0] DEP = CW'(DEPTH);

    typedef enum logic [1:0] {CTP_IDLE, CTP_ARMED, CTP_POST, CTP_DONE} ctp_state_e;

    ////////////////////////////////////////////////////////////////
    // Registers seen by software
    logic [3:0] ctrl;                  // Power-up enable, segmented mode
    logic [5:0] rt_cfg;                // Run-time set: ratio, input, output level
    logic [5:0] pu_cfg;                // Power-up set, same layout
    logic [`CTP_IRQ_W-1:0] irq_stat;   // Sticky events
    logic [`CTP_IRQ_W-1:0] irq_mask;   // Enables onto irq
    logic [CW-1:0] trig_idx;           // Reported trigger sample index
    logic pu_phase;                    // High while power-up set governs
    ctp_state_e state;
    logic [CW-1:0] pre_cnt;            // Samples stored since buffer start
    logic tin_prev;                    // Previous trigger input for edges
    logic [SW-1:0] seg;                // Current segment
    logic tout;                        // Trigger output register
    logic seg_post;                    // Post-fill running for a segment
    logic tin_seen;                    // Trigger input already satisfied this run
    logic pu_armed_once;               // A run has started since reset
    logic pu_go;                       // Power-up set may arm now

    logic [3:0] next_ctrl;
    logic [5:0] next_rt_cfg, next_pu_cfg;
    logic [`CTP_IRQ_W-1:0] next_irq_stat, next_irq_mask, ev;
    logic [CW-1:0] next_trig_idx, next_pre_cnt;
    logic next_pu_phase, next_tout, next_seg_post;
    ctp_state_e next_state;
    logic [SW-1:0] next_seg;
    logic next_tin_seen;

    ctp_fill_if #(.CW(CW)) fill ();

    ctp_fill_counter #(.CW(CW)) u_fill (
        .clk(clk),
        .rst_b(rst_b),
        .ce(ce),
        .fill(fill)
    );

    ////////////////////////////////////////////////////////////////
    // Active set selection: one set of fields at a time
    logic [5:0] cfg;
    logic tin_hit, tin_ok, cond, trig_fire, pol;
    ctp_pat_e pat;
    logic [CW-1:0] post_amt, ratio_post, act_post;
    assign cfg = pu_phase ? pu_cfg : rt_cfg;
    assign pat = ctp_pat_e'(cfg[`CTP_CFG_TIN_PAT_MSB:`CTP_CFG_TIN_PAT_LSB]);
    assign pol = cfg[`CTP_CFG_TOUT_HIGH];

    // Trigger input match; same pin for both sets
    always_comb
    begin
        unique case (pat)
            CTP_PAT_LOW: tin_hit = !trig_in;
            CTP_PAT_HIGH: tin_hit = trig_in;
            CTP_PAT_RISE: tin_hit = trig_in && !tin_prev;
            CTP_PAT_FALL: tin_hit = !trig_in && tin_prev;
        endcase
    end
    // Input gates the rest when enabled
    // A one-cycle edge is latched, so a sample gap cannot lose it
    assign tin_ok = !cfg[`CTP_CFG_TIN_EN] || tin_hit || tin_seen;
    assign cond = pu_phase ? cond_pu : cond_rt;
    assign trig_fire = tin_ok && cond;

    // Post-trigger length for the fixed ratios
    function automatic logic [CW-1:0] ratio_len(input logic [1:0] r);
        logic [CW+7:0] prod;
        prod = '0;
        unique case (ctp_ratio_e'(r))
            CTP_RATIO_EARLY: prod = (CW+8)'(DEPTH * `CTP_PCT_LATE / `CTP_PCT_FULL);
            CTP_RATIO_LATE: prod = (CW+8)'(DEPTH * `CTP_PCT_EARLY / `CTP_PCT_FULL);
            default: prod = (CW+8)'(DEPTH * `CTP_PCT_HALF / `CTP_PCT_FULL);
        endcase
        return prod[CW-1:0];
    endfunction : ratio_len

    assign ratio_post = ratio_len(cfg[`CTP_CFG_RATIO_MSB:`CTP_CFG_RATIO_LSB]);
    // Explicit count wins, else ratio, limited to depth
    assign post_amt = fill_valid ? fill_count : ratio_post;
    assign act_post = (post_amt > DEP) ? DEP : post_amt;

    ////////////////////////////////////////////////////////////////
    // Capture sequencing and register file next values
    always_comb
    begin
        next_ctrl = ctrl;
        next_rt_cfg = rt_cfg;
        next_pu_cfg = pu_cfg;
        next_irq_mask = irq_mask;
        next_trig_idx = trig_idx;
        next_pu_phase = pu_phase;
        next_state = state;
        next_pre_cnt = pre_cnt;
        next_seg = seg;
        next_tout = tout;
        next_seg_post = seg_post;
        next_tin_seen = tin_seen;
        ev = '0;
        fill.load = 1'b0;
        fill.amount = act_post;
        fill.step = 1'b0;
        next_irq_stat = irq_stat;
        // Software writes
        if (wr)
        begin
            unique case (addr)
                `CTP_ADDR_CTRL: next_ctrl = wdata[3:0];
                `CTP_ADDR_RT_CFG: next_rt_cfg = wdata[5:0];
                `CTP_ADDR_PU_CFG: next_pu_cfg = wdata[5:0];
                `CTP_ADDR_IRQ_STAT: next_irq_stat = irq_stat & ~wdata[`CTP_IRQ_W-1:0];
                `CTP_ADDR_IRQ_MASK: next_irq_mask = wdata[`CTP_IRQ_W-1:0];
                default: ;
            endcase
        end
        // Sample storage counters advance on each stored sample
        if (store_en)
        begin
            next_pre_cnt = (pre_cnt == DEP) ? DEP : pre_cnt + 1'b1;
            fill.step = 1'b1;
        end
        unique case (state)
            CTP_IDLE, CTP_DONE:
            begin
                if (wr && addr == `CTP_ADDR_CTRL && wdata[`CTP_CTRL_START])
                begin
                    // Re-arm with the run-time set, output inactive
                    next_state = CTP_ARMED;
                    next_pu_phase = 1'b0;
                    next_pre_cnt = '0;
                    next_seg = '0;
                    next_tin_seen = 1'b0;
                    next_tout = !rt_cfg[`CTP_CFG_TOUT_HIGH];
                end
                else if (state == CTP_IDLE && pu_go)
                begin
                    // Power-up set arms with no start command
                    next_state = CTP_ARMED;
                    next_pu_phase = 1'b1;
                    next_pre_cnt = '0;
                    next_seg = '0;
                    next_tin_seen = 1'b0;
                    next_tout = !pu_cfg[`CTP_CFG_TOUT_HIGH];
                end
            end
            CTP_ARMED:
            begin
                next_tout = !pol;
                // Input condition stays met once seen, until re-arm
                if (cfg[`CTP_CFG_TIN_EN] && tin_hit)
                    next_tin_seen = 1'b1;
                if (ctrl[`CTP_CTRL_SEGMENTED] && seg_close && sample_valid && !seg_post)
                begin
                    // Segment close: fill then advance, wrapping to oldest
                    fill.load = 1'b1;
                    next_seg_post = 1'b1;
                end
                if (trig_fire && sample_valid)
                begin
                    fill.load = 1'b1;
                    next_seg_post = 1'b0;
                    next_trig_idx = DEP - act_post;
                    next_tout = pol;
                    next_state = CTP_POST;
                    ev[`CTP_IRQ_TRIG] = 1'b1;
                end
                else if (seg_post && fill.done)
                begin
                    next_seg_post = 1'b0;
                    next_seg = (seg == SW'(SEGS - 1)) ? '0 : seg + 1'b1;
                    next_pre_cnt = '0;
                    ev[`CTP_IRQ_SEG] = 1'b1;
                end
            end
            CTP_POST:
            begin
                if (fill.done)
                begin
                    next_state = CTP_DONE;
                    ev[`CTP_IRQ_DONE] = 1'b1;
                end
            end
        endcase
        // Stop from software ends any run at once
        if (wr && addr == `CTP_ADDR_CTRL && wdata[`CTP_CTRL_STOP] && state != CTP_IDLE)
            next_state = CTP_DONE;
        // Set wins over clear
        next_irq_stat = next_irq_stat | ev;
    end

    // Storage enable: armed or post-filling, sample present
    assign store_en = sample_valid && (state == CTP_ARMED || (state == CTP_POST && !fill.done));

    ////////////////////////////////////////////////////////////////
    // State registers; power-up arming waits for the enable bit, which reset clears
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            ctrl <= `CTP_CTRL_RESET;
            rt_cfg <= `CTP_CFG_RESET;
            pu_cfg <= `CTP_CFG_RESET;
            irq_stat <= '0;
            irq_mask <= '0;
            trig_idx <= '0;
            pu_phase <= 1'b0;
            state <= CTP_IDLE;
            pre_cnt <= '0;
            seg <= '0;
            tout <= 1'b0;
            seg_post <= 1'b0;
            tin_seen <= 1'b0;
            tin_prev <= 1'b0;
        end
        else if (ce)
        begin
            ctrl <= next_ctrl;
            rt_cfg <= next_rt_cfg;
            pu_cfg <= next_pu_cfg;
            irq_stat <= next_irq_stat;
            irq_mask <= next_irq_mask;
            trig_idx <= next_trig_idx;
            pu_phase <= next_pu_phase;
            state <= next_state;
            pre_cnt <= next_pre_cnt;
            seg <= next_seg;
            tout <= next_tout;
            seg_post <= next_seg_post;
            tin_seen <= next_tin_seen;
            tin_prev <= trig_in;
        end
    end

    // Power-up arming: configuration ends at reset release, so the
    // enable bit arms the power-up set only until the first run starts;
    // later runs belong to the run-time set.
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            pu_armed_once <= 1'b0;
        else if (ce)
            pu_armed_once <= pu_armed_once || (state != CTP_IDLE);
    end
    assign pu_go = !pu_armed_once && ctrl[`CTP_CTRL_PU_EN];

    ////////////////////////////////////////////////////////////////
    // Read port: data one cycle after the strobe
    logic [31:0] next_rdata;
    always_comb
    begin
        next_rdata = '0;
        if (rd)
        begin
            unique case (addr)
                `CTP_ADDR_CTRL: next_rdata = {28'h0000000, ctrl};
                `CTP_ADDR_RT_CFG: next_rdata = {26'h0000000, rt_cfg};
                `CTP_ADDR_PU_CFG: next_rdata = {26'h0000000, pu_cfg};
                `CTP_ADDR_STATUS: next_rdata = {28'h0000000, tout, pu_phase, state};
                `CTP_ADDR_IRQ_STAT: next_rdata = {29'h00000000, irq_stat};
                `CTP_ADDR_IRQ_MASK: next_rdata = {29'h00000000, irq_mask};
                `CTP_ADDR_TRIG_IDX: next_rdata = {{(32-CW){1'b0}}, trig_idx};
                `CTP_ADDR_SEG_SEL: next_rdata = {{(32-SW){1'b0}}, seg};
                default: next_rdata = '0;
            endcase
        end
    end
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            rdata <= '0;
        else if (ce)
            rdata <= next_rdata;
    end

    assign wr_ptr = pre_cnt;
    assign seg_idx = seg;
    assign trig_out = tout;
    assign irq = |(irq_stat & irq_mask);
endmodule : ctp_capture_ctrl
`default_nettype wire

// File: verif/ctp_capture_ctrl_props.sv
// Port checker for the capture trigger position controller.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module ctp_capture_ctrl_props #(
    parameter int DEPTH = 512, // Samples per buffer or segment
    parameter int SEGS = 4, // Segment count
    parameter int CW = 10 // Counter width
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic wr,
    input wire logic rd,
    input wire logic [31:0] rdata,
    input wire logic sample_valid,
    input wire logic store_en,
    input wire logic [CW-1:0] wr_ptr,
    input wire logic [$clog2(SEGS)-1:0] seg_idx,
    input wire logic trig_out,
    input wire logic irq
);
    // One domain, so clock and reset are shared by every property
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    ////////////////////////////////////////////////////////////////////////////
    // Read data stands only in the cycle after a read
    a_rdata_idle: assert property (!rd |=> rdata == 32'h0)
        else $error("read data not zero outside a read answer");
    a_store_valid: assert property (store_en |-> sample_valid)
        else $error("sample stored with no sample offered");
    // A low enable must freeze the write pointer, segment index and trigger output
    a_freeze_ce: assert property (!ce |=> $stable(wr_ptr) && $stable(seg_idx) && $stable(trig_out))
        else $error("state moved while enable low");
    a_ptr_bound: assert property (wr_ptr <= DEPTH)
        else $error("store count beyond depth");
    a_seg_bound: assert property (seg_idx < SEGS)
        else $error("segment index out of range");
    // Segments advance one at a time and wrap to the oldest
    a_seg_order: assert property ($changed(seg_idx) |-> seg_idx == $past(seg_idx) + 1'h1 || seg_idx == '0)
        else $error("segment index skipped");
    // Reset edge is excluded: the idle level may settle right after it
    a_trig_cause: assert property ($changed(trig_out) && $past(rst_b) |-> $past(wr) || $past(sample_valid))
        else $error("trigger output moved with no cause");
    a_irq_clear: assert property ($fell(irq) && $past(rst_b) |-> $past(wr))
        else $error("interrupt dropped without a write");
endmodule : ctp_capture_ctrl_props

bind ctp_capture_ctrl ctp_capture_ctrl_props #(.DEPTH(DEPTH), .SEGS(SEGS), .CW(CW)) u_props (
    .clk(clk), .rst_b(rst_b), .ce(ce), .wr(wr), .rd(rd), .rdata(rdata), .sample_valid(sample_valid),
    .store_en(store_en), .wr_ptr(wr_ptr), .seg_idx(seg_idx), .trig_out(trig_out), .irq(irq));
`default_nettype wire

// File: verif/ctp_ext_src.sv
// Far-side model: sampled design and external trigger equipment.
// Assumes the bench sets run and lvl just after clock edges.
`timescale 1ns/1ps
`default_nettype none
module ctp_ext_src (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic run, // Offer samples
    input wire logic lvl, // Wanted trigger input level
    output logic sample_valid,
    output logic trig_in
);
    logic [1:0] gap; // Stall phase counter

    ////////////////////////////////////////////////////////////////////////////
    // Every fourth cycle offers no sample, so counts cannot lean on cycles
    always_ff @(posedge clk)
    begin
        gap <= rst_b ? gap + 2'h1 : 2'h0;
        sample_valid <= rst_b && run && gap != 2'h3;
        trig_in <= lvl;
    end
endmodule : ctp_ext_src
`default_nettype wire

// File: verif/ctp_capture_ctrl_tb.sv
// Self-checking bench for the capture trigger position controller.
// Assumes design, checker and far-side model are compiled before it.
`include "ctp_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module ctp_capture_ctrl_tb;
    localparam int DEPTH = 100; // Percent splits come out whole
    localparam int SEGS = 3; // Odd count exercises the wrap
    localparam int CW = 10;
    localparam int POST [3] = '{88, 50, 12}; // Post samples per ratio
    logic clk = 1'h0;
    logic rst_b = 1'h0;
    logic ce = 1'h1;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'h0;
    logic rd = 1'h0;
    logic cond_rt = 1'h0;
    logic seg_close = 1'h0;
    logic fill_valid = 1'h0;
    logic [CW-1:0] fill_count = '0;
    logic run = 1'h0; // Far side offers samples
    logic lvl = 1'h0; // Far side trigger level
    logic act = 1'h1; // Active output level of this run
    logic [31:0] rdata;
    logic sample_valid, trig_in, store_en, trig_out, irq;
    logic [CW-1:0] wr_ptr;
    logic [1:0] seg_idx;
    int num_errors = 0;
    int check_count = 0;
    int post_seen = 0; // Samples stored once the output went active
    int i;

    ctp_capture_ctrl #(.DEPTH(DEPTH), .SEGS(SEGS), .CW(CW)) DUT (
        .clk(clk), .rst_b(rst_b), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .sample_valid(sample_valid), .trig_in(trig_in), .cond_rt(cond_rt),
        .cond_pu(1'h0), .seg_close(seg_close), .fill_valid(fill_valid), .fill_count(fill_count),
        .store_en(store_en), .wr_ptr(wr_ptr), .seg_idx(seg_idx), .trig_out(trig_out), .irq(irq));
    ctp_ext_src u_src (.clk(clk), .rst_b(rst_b), .run(run), .lvl(lvl),
        .sample_valid(sample_valid), .trig_in(trig_in));

    initial
    begin
        forever #5 clk = ~clk;
    end
    // Count only after the edge that showed the active level
    always @(posedge clk)
    begin
        if (store_en === 1'h1 && trig_out === act)
            post_seen++;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic summarize;
        $display("errors %0d, checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : summarize
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            num_errors++;
        end
    endtask : chk
    // A wait that used its whole bound ends the run
    task automatic tmo(input int k, input int lim);
        if (k >= lim)
        begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, k, lim);
            num_errors++;
            summarize();
        end
    endtask : tmo
    task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
        #1;
    endtask : bus_wr
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'h1;
        @(posedge clk);
        rd <= 1'h0;
        #1;
        chk(rdata, exp);
    endtask : rd_chk
    // Arm, hold the condition until the output flips, then await done
    task automatic run_trig(input logic [31:0] cfg, input logic fv, input logic [CW-1:0] fc, input int post);
        int k;
        act = cfg[`CTP_CFG_TOUT_HIGH];
        lvl <= cfg[4:3] == 2'h0 || cfg[4:3] == 2'h3; // Idle level never matches
        bus_wr(`CTP_ADDR_IRQ_STAT, 32'h7);
        bus_wr(`CTP_ADDR_RT_CFG, cfg);
        bus_wr(`CTP_ADDR_CTRL, 32'h1);
        chk(trig_out, !act);
        post_seen = 0;
        ce <= 1'h0;
        repeat (3) @(posedge clk);
        ce <= 1'h1;
        cond_rt <= 1'h1;
        fill_valid <= fv;
        fill_count <= fc;
        if (cfg[`CTP_CFG_TIN_EN])
        begin
            repeat (20) @(posedge clk);
            #1 chk(trig_out, !act);
            lvl <= ~lvl;
        end
        for (k = 0; k < 60 && trig_out !== act; k++) @(posedge clk);
        tmo(k, 60);
        cond_rt <= 1'h0;
        fill_valid <= 1'h0;
        #1 chk(trig_out, act);
        for (k = 0; k < 400 && irq !== 1'h1; k++) @(posedge clk);
        tmo(k, 400);
        #1 chk(post_seen, post);
        rd_chk(`CTP_ADDR_TRIG_IDX, DEPTH - post);
        rd_chk(`CTP_ADDR_IRQ_STAT, 32'h5);
    endtask : run_trig

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (2) @(posedge clk);
        rst_b <= 1'h1;
        rd_chk(`CTP_ADDR_CTRL, 32'h0);
        rd_chk(`CTP_ADDR_RT_CFG, 32'h1);
        rd_chk(`CTP_ADDR_PU_CFG, 32'h1);
        rd_chk(`CTP_ADDR_IRQ_MASK, 32'h0);
        bus_wr(4'hF, 32'hFFFF_FFFF);
        rd_chk(4'hF, 32'h0);
        bus_wr(`CTP_ADDR_PU_CFG, 32'h3A);
        rd_chk(`CTP_ADDR_PU_CFG, 32'h3A);
        rd_chk(`CTP_ADDR_RT_CFG, 32'h1);
        bus_wr(`CTP_ADDR_IRQ_MASK, 32'h4);
        run <= 1'h1;
        // Each fixed ratio, output level alternating
        for (i = 0; i < 3; i++)
            run_trig(32'(i) | (i[0] ? 32'h20 : 32'h0), 1'h0, '0, POST[i]);
        bus_wr(`CTP_ADDR_IRQ_STAT, 32'h7);
        rd_chk(`CTP_ADDR_IRQ_STAT, 32'h0);
        chk(irq, 1'h0);
        // Every input pattern, with a short post-fill count
        for (i = 0; i < 4; i++)
            run_trig(32'h24 | 32'(i << 3), 1'h1, CW'(i + 1), i + 1);
        bus_wr(`CTP_ADDR_IRQ_STAT, 32'h7);
        bus_wr(`CTP_ADDR_CTRL, 32'h9);
        // Close segments past the last one to see the wrap
        for (i = 1; i <= 4; i++)
        begin
            seg_close <= 1'h1;
            fill_valid <= 1'h1;
            fill_count <= 10'h2;
            for (int k = 0; k < 8; k++)
            begin
                @(posedge clk);
                if (store_en === 1'h1)
                    break;
            end
            seg_close <= 1'h0;
            fill_valid <= 1'h0;
            for (int k = 0; k < 60 && seg_idx !== 2'(i % SEGS); k++) @(posedge clk);
            #1 chk(seg_idx, i % SEGS);
        end
        rd_chk(`CTP_ADDR_IRQ_STAT, 32'h2);
        chk(irq, 1'h0);
        bus_wr(`CTP_ADDR_CTRL, 32'h2);
        summarize();
    end
endmodule : ctp_capture_ctrl_tb
`default_nettype wire
